// ==== verilog/sesr_params.svh ====
// Offsets, field positions and reset values for the status system
`ifndef SESR_PARAMS_SVH
`define SESR_PARAMS_SVH
`define SESR_SEL_STD_EVENT 3'h0
`define SESR_SEL_STD_ENABLE 3'h1
`define SESR_SEL_OP_EVENT 3'h2
`define SESR_SEL_OP_ENABLE 3'h3
`define SESR_SEL_OP_COND 3'h4
`define SESR_SEL_STATUS_BYTE 3'h5
`define SESR_SEL_SRQ_ENABLE 3'h6
`define SESR_BIT_PON 7
`define SESR_BIT_CME 5
`define SESR_BIT_EXE 4
`define SESR_BIT_QYE 2
`define SESR_BIT_OPC 0
`define SESR_BIT_OSB 7
`define SESR_BIT_MSS 6
`define SESR_BIT_ESB 5
`define SESR_BIT_MAV 4
`define SESR_STD_EVENT_RESET 8'h80
`define SESR_ZERO_BYTE 8'h00
`endif

// ==== verilog/sesr_pkg.sv ====
// Types shared by the status system modules
package sesr_pkg;
   typedef logic [7:0] sesr_byte_type;
   typedef enum logic [1:0] {
      SESR_OPC_IDLE,
      SESR_OPC_ARMED
   } sesr_opc_state_type;
endpackage : sesr_pkg

// ==== verilog/sesr_event_if.sv ====
// Event register set carrier between top and event latch module
interface sesr_event_if;
   logic [7:0] set_events;
   logic clear;
   logic [7:0] enable;
   logic [7:0] events;
   logic summary;
   modport latch (input set_events, input clear, input enable, output events, output summary);
   modport owner (output set_events, output clear, output enable, input events, input summary);
endinterface : sesr_event_if

// ==== verilog/sesr_event_set.sv ====
// One latched event register with enable-masked summary
`include "sesr_params.svh"

module sesr_event_set #(
   parameter logic [7:0] RESET_VALUE = 8'h00
) (
   input wire logic mclk, // Clock
   input wire logic rst_b, // Async reset, active low
   input wire logic clk_en, // Clock enable
   sesr_event_if.latch ev // Event carrier
);
   sesr_pkg::sesr_byte_type latched;

   // Set wins over clear so an event in the clearing cycle is kept
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         latched <= RESET_VALUE;
      end else if (clk_en) begin
         latched <= (ev.clear ? `SESR_ZERO_BYTE : latched) | ev.set_events;
      end
   end

   assign ev.events = latched;
   assign ev.summary = |(latched & ev.enable); // RULE_12 RULE_13 RULE_15
endmodule : sesr_event_set

// ==== verilog/sesr_status_top.sv ====
// Status byte, event register sets and service request generation
`include "sesr_params.svh"

// Functional notes
// RULE_01 - Power-on flag at standard event bit 7 marks an off-to-on transition.
// RULE_02 - Command error sets standard event bit 5.
// RULE_03 - Execution error sets standard event bit 4.
// RULE_04 - Output queue overflow losing data sets standard event bit 2.
// RULE_05 - After operation-complete command, bit 0 sets when pending work ends.
// RULE_06 - Reading standard event register returns then clears it; enable is read/write.
// RULE_07 - Operation bit 7 comm failure, bit 6 calibration data bad.
// RULE_08 - Operation bit 5 autotune idle, bit 4 new reading.
// RULE_09 - Operation bit 3 loop 1 ramp done, bit 2 loop 2 ramp done.
// RULE_10 - Operation bit 1 overload, bit 0 alarm when alarm visible.
// RULE_11 - Operation event read clears; condition read is live; enable is read/write.
// RULE_12 - Status bit 7 is OR of enabled operation events.
// RULE_13 - Status bit 5 is OR of enabled standard events.
// RULE_14 - Status bit 4 follows output buffer holding a message.
// RULE_15 - Summary bits do not latch; they follow their sources.
// RULE_16 - Master summary is OR of summaries masked by service enable.
// RULE_17 - Rising master summary sets request flag and asserts service line.
// RULE_18 - Serial poll clears request flag and line, not master summary.
// RULE_19 - No new request after poll until master summary falls again.
// RULE_20 - Status query returns poll value with master summary, clears nothing.
// RULE_21 - Controller polls on request, then reads causing event register.
// RULE_22 - Values are 8-bit binary weighted; only enables are writable.
// RULE_23 - Clear-status clears both event registers; zero write clears enable.
// RULE_24 - Reset clears all flags except power-on event flag.
module sesr_status_top (
   input wire logic mclk, // 40 MHz clock
   input wire logic rst_b, // Power-on reset, active low
   input wire logic clk_en, // Freezes all state when low
   input wire logic command_error, // Pulse: uninterpretable command
   input wire logic execution_error, // Pulse: action outside capabilities
   input wire logic query_error, // Pulse: response lost, queue full
   input wire logic opc_command, // Pulse: operation-complete command received
   input wire logic ops_pending, // Level: operations still pending
   input wire logic [7:0] op_conditions, // Live operation conditions
   input wire logic message_available, // Output buffer holds a message
   input wire logic clear_status, // Pulse: clear-status command
   input wire logic serial_poll, // Pulse: serial poll performed
   input wire logic reg_write, // Pulse: write enable register
   input wire logic reg_read, // Pulse: read register
   input wire logic [2:0] reg_sel, // Register select
   input wire logic [7:0] reg_wdata, // Write data
   output logic [7:0] reg_rdata, // Read data, registered
   output logic reg_rvalid, // Read data valid pulse
   output logic [7:0] poll_byte, // Serial poll response, registered
   output logic poll_valid, // Poll response valid pulse
   output logic srq_line, // Bus service request line, active high
   output logic [7:0] status_byte // Live status byte, registered copy
);
   sesr_event_if std_if();
   sesr_event_if op_if();
   sesr_pkg::sesr_byte_type std_enable;
   sesr_pkg::sesr_byte_type op_enable;
   sesr_pkg::sesr_byte_type service_request_enable;
   sesr_pkg::sesr_byte_type op_cond_prev;
   sesr_pkg::sesr_opc_state_type opc_state;
   logic request_service_flag;
   logic mss_prev;
   logic master_summary;
   logic operation_completed;
   logic [7:0] summary_bits;
   logic [7:0] std_set;
   logic [7:0] op_set;
   logic read_std;
   logic read_op;

   function automatic logic sel_hit(input logic [2:0] sel, input logic [2:0] code);
      sel_hit = (sel == code);
   endfunction : sel_hit

   assign read_std = reg_read && sel_hit(reg_sel, `SESR_SEL_STD_EVENT);
   assign read_op = reg_read && sel_hit(reg_sel, `SESR_SEL_OP_EVENT);

   // Operation-complete waits for pending work after the command
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         opc_state <= sesr_pkg::SESR_OPC_IDLE;
      end else if (clk_en) begin
         unique case (opc_state)
            sesr_pkg::SESR_OPC_IDLE: begin
               if (opc_command) begin
                  opc_state <= sesr_pkg::SESR_OPC_ARMED;
               end
            end
            sesr_pkg::SESR_OPC_ARMED: begin
               if (!ops_pending) begin
                  opc_state <= sesr_pkg::SESR_OPC_IDLE; // RULE_05
               end
            end
         endcase
      end
   end

   assign operation_completed = (opc_state == sesr_pkg::SESR_OPC_ARMED) && !ops_pending;

   always_comb begin
      std_set = `SESR_ZERO_BYTE;
      std_set[`SESR_BIT_CME] = command_error; // RULE_02
      std_set[`SESR_BIT_EXE] = execution_error; // RULE_03
      std_set[`SESR_BIT_QYE] = query_error; // RULE_04
      std_set[`SESR_BIT_OPC] = operation_completed; // RULE_05
   end

   // Operation events latch on a condition becoming true; edge avoids
   // refilling a register from a level the host just cleared
   assign op_set = op_conditions & ~op_cond_prev; // RULE_07 RULE_08 RULE_09 RULE_10

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         op_cond_prev <= `SESR_ZERO_BYTE;
      end else if (clk_en) begin
         op_cond_prev <= op_conditions;
      end
   end

   assign std_if.set_events = std_set;
   assign std_if.clear = read_std || clear_status; // RULE_06 RULE_23
   assign std_if.enable = std_enable;
   assign op_if.set_events = op_set;
   assign op_if.clear = read_op || clear_status; // RULE_11 RULE_23
   assign op_if.enable = op_enable;

   // Power-on flag comes from the reset value
   sesr_event_set #(
      .RESET_VALUE(`SESR_STD_EVENT_RESET) // RULE_01 RULE_24
   ) u_std (
      .mclk(mclk),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .ev(std_if.latch)
   );

   sesr_event_set #(
      .RESET_VALUE(`SESR_ZERO_BYTE)
   ) u_op (
      .mclk(mclk),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .ev(op_if.latch)
   );

   // Enable registers; a write of zero simply stores zero
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         std_enable <= `SESR_ZERO_BYTE; // RULE_24
         op_enable <= `SESR_ZERO_BYTE;
         service_request_enable <= `SESR_ZERO_BYTE;
      end else if (clk_en && reg_write) begin
         if (sel_hit(reg_sel, `SESR_SEL_STD_ENABLE)) begin
            std_enable <= reg_wdata; // RULE_06 RULE_22 RULE_23
         end
         if (sel_hit(reg_sel, `SESR_SEL_OP_ENABLE)) begin
            op_enable <= reg_wdata; // RULE_11
         end
         if (sel_hit(reg_sel, `SESR_SEL_SRQ_ENABLE)) begin
            service_request_enable[7] <= reg_wdata[7];
            service_request_enable[5:0] <= reg_wdata[5:0];
         end
      end
   end

   always_comb begin
      summary_bits = `SESR_ZERO_BYTE;
      summary_bits[`SESR_BIT_OSB] = op_if.summary; // RULE_12 RULE_15
      summary_bits[`SESR_BIT_ESB] = std_if.summary; // RULE_13 RULE_15
      summary_bits[`SESR_BIT_MAV] = message_available; // RULE_14
   end

   assign master_summary = |(summary_bits & service_request_enable); // RULE_16

   // Request flag rises only on a master summary edge, so after a poll it
   // stays quiet until the causing register clears and a new edge comes
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         mss_prev <= 1'b0;
         request_service_flag <= 1'b0; // RULE_24
      end else if (clk_en) begin
         mss_prev <= master_summary;
         if (master_summary && !mss_prev) begin
            request_service_flag <= 1'b1; // RULE_17 RULE_19
         end else if (serial_poll) begin
            request_service_flag <= 1'b0; // RULE_18
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         srq_line <= 1'b0;
      end else if (clk_en) begin
         srq_line <= (master_summary && !mss_prev) ||
                     (request_service_flag && !serial_poll); // RULE_17 RULE_18
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         status_byte <= `SESR_ZERO_BYTE;
      end else if (clk_en) begin
         status_byte <= summary_bits | {1'b0, master_summary, 6'h00}; // RULE_16
      end
   end

   // Poll reports the request flag in bit 6
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         poll_byte <= `SESR_ZERO_BYTE;
         poll_valid <= 1'b0;
      end else if (clk_en) begin
         poll_valid <= serial_poll;
         if (serial_poll) begin
            poll_byte <= summary_bits | {1'b0, request_service_flag, 6'h00}; // RULE_18
         end
      end
   end

   // Read mux; the status byte query reports master summary, clears nothing
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= `SESR_ZERO_BYTE;
         reg_rvalid <= 1'b0;
      end else if (clk_en) begin
         reg_rvalid <= reg_read;
         if (reg_read) begin
            unique case (reg_sel)
               `SESR_SEL_STD_EVENT: reg_rdata <= std_if.events; // RULE_06
               `SESR_SEL_STD_ENABLE: reg_rdata <= std_enable;
               `SESR_SEL_OP_EVENT: reg_rdata <= op_if.events; // RULE_11
               `SESR_SEL_OP_ENABLE: reg_rdata <= op_enable;
               `SESR_SEL_OP_COND: reg_rdata <= op_conditions; // RULE_11
               `SESR_SEL_STATUS_BYTE: begin
                  reg_rdata <= summary_bits | {1'b0, master_summary, 6'h00}; // RULE_20
               end
               `SESR_SEL_SRQ_ENABLE: reg_rdata <= service_request_enable; // RULE_22
               default: reg_rdata <= `SESR_ZERO_BYTE;
            endcase
         end
      end
   end
endmodule : sesr_status_top

// ==== testbench/sesr_host_model.sv ====
// Bus controller model: serial polls the device after a service request
module sesr_host_model (
   input wire logic mclk, // Clock
   input wire logic rst_b, // Reset, active low
   input wire logic srq_line, // Service request
   input wire logic poll_valid, // Poll answer strobe
   input wire logic [3:0] poll_delay, // Cycles before polling
   output logic serial_poll // Poll pulse
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] wait_cnt;
   logic busy;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         wait_cnt <= 4'h0;
         busy <= 1'b0;
         serial_poll <= 1'b0;
      end else begin
         serial_poll <= 1'b0;
         if (busy) begin
            busy <= !poll_valid;
         end else if (srq_line) begin
            wait_cnt <= wait_cnt + 4'h1;
            if (wait_cnt >= poll_delay) begin
               serial_poll <= 1'b1;
               busy <= 1'b1;
               wait_cnt <= 4'h0;
            end
         end
      end
   end
endmodule : sesr_host_model

// ==== testbench/sesr_status_sva.sv ====
// Checker for status byte, poll and service request timing
module sesr_status_sva (
   input wire logic mclk, // Clock
   input wire logic rst_b, // Reset
   input wire logic clk_en, // Enable
   input wire logic message_available, // Buffer flag
   input wire logic serial_poll, // Poll
   input wire logic reg_read, // Read
   input wire logic [2:0] reg_sel, // Select
   input wire logic [7:0] reg_rdata, // Read data
   input wire logic reg_rvalid, // Read valid
   input wire logic [7:0] poll_byte, // Poll data
   input wire logic poll_valid, // Poll valid
   input wire logic srq_line, // Request line
   input wire logic [7:0] status_byte // Status
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);
   a_read_answer: assert property (reg_read && clk_en |=> reg_rvalid)
      else $error("read not answered");
   a_query_same: assert property (reg_read && clk_en && reg_sel == 3'h5 |=> reg_rdata == status_byte)
      else $error("status query differs");
   a_mav_follow: assert property (clk_en |=> status_byte[4] == $past(message_available))
      else $error("message bit wrong");
   a_srq_on_rise: assert property ($rose(status_byte[6]) |-> srq_line)
      else $error("no request on rise");
   a_srq_cause: assert property ($rose(srq_line) |-> $rose(status_byte[6]))
      else $error("request without rise");
   a_srq_holds: assert property (srq_line && !serial_poll |=> srq_line)
      else $error("request dropped");
   a_poll_clears: assert property (serial_poll && clk_en && status_byte[6] |=> !srq_line && poll_valid)
      else $error("poll kept request");
   a_poll_bits: assert property (poll_valid |-> (poll_byte & 8'hB0) == (status_byte & 8'hB0))
      else $error("poll summary differs");
   c_poll: cover property (poll_valid && poll_byte[6]);
   c_query: cover property (reg_read && reg_sel == 3'h5);
   c_srq: cover property ($rose(srq_line));
endmodule : sesr_status_sva
bind sesr_status_top sesr_status_sva sesr_status_sva_i (.mclk, .rst_b, .clk_en,
   .message_available, .serial_poll, .reg_read, .reg_sel, .reg_rdata, .reg_rvalid,
   .poll_byte, .poll_valid, .srq_line, .status_byte);

// ==== testbench/sesr_status_top_tb.sv ====
// Self-checking bench for the status system
module sesr_status_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, rst_b, clk_en, ops_pending, message_available, serial_poll;
   logic reg_write, reg_read, reg_rvalid, poll_valid, srq_line;
   logic [4:0] ev;
   logic [2:0] reg_sel;
   logic [3:0] poll_delay;
   logic [7:0] op_conditions, reg_wdata, reg_rdata, poll_byte, status_byte;
   int fails, samples_checked;
   sesr_status_top sesr_status_top_i (.mclk, .rst_b, .clk_en, .command_error(ev[0]),
      .execution_error(ev[1]), .query_error(ev[2]), .opc_command(ev[3]), .ops_pending,
      .op_conditions, .message_available, .clear_status(ev[4]), .serial_poll,
      .reg_write, .reg_read, .reg_sel, .reg_wdata, .reg_rdata, .reg_rvalid,
      .poll_byte, .poll_valid, .srq_line, .status_byte);
   sesr_host_model sesr_host_model_i (.mclk, .rst_b, .srq_line, .poll_valid,
      .poll_delay, .serial_poll);
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : step
   task automatic rd(input logic [2:0] sel, input logic [7:0] exp);
      reg_sel = sel;
      reg_read = 1'b1;
      step(1);
      reg_read = 1'b0;
      check("rvalid", {7'h00, reg_rvalid}, 8'h01);
      check("rdata", reg_rdata, exp);
   endtask : rd
   task automatic wr(input logic [2:0] sel, input logic [7:0] data);
      reg_sel = sel;
      reg_wdata = data;
      reg_write = 1'b1;
      step(1);
      reg_write = 1'b0;
   endtask : wr
   task automatic hit(input logic [4:0] v, input logic [2:0] sel, input logic [7:0] exp);
      ev = v;
      step(1);
      ev = 5'h00;
      rd(sel, exp);
   endtask : hit
   task automatic wait_poll(input logic [7:0] exp);
      int n;
      n = 0;
      while (poll_valid !== 1'b1 && n < 40) begin
         step(1);
         n++;
      end
      check("poll_byte", poll_byte, exp);
      check("srq_line", {7'h00, srq_line}, 8'h00);
   endtask : wait_poll
   task automatic wrap_up();
      $display("Checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : wrap_up
   initial begin
      #100000;
      fails++;
      wrap_up();
   end
   initial begin
      rst_b = 1'b0;
      clk_en = 1'b1;
      ev = 5'h00;
      ops_pending = 1'b0;
      message_available = 1'b0;
      op_conditions = 8'h00;
      reg_write = 1'b0;
      reg_read = 1'b0;
      reg_sel = 3'h0;
      reg_wdata = 8'h00;
      poll_delay = 4'h1;
      fails = 0;
      samples_checked = 0;
      repeat (3) @(posedge mclk);
      #1 rst_b = 1'b1;
      rd(3'h0, 8'h80);
      rd(3'h0, 8'h00);
      hit(5'h01, 3'h0, 8'h20);
      hit(5'h02, 3'h0, 8'h10);
      hit(5'h04, 3'h0, 8'h04);
      ops_pending = 1'b1;
      hit(5'h08, 3'h0, 8'h00);
      ops_pending = 1'b0;
      step(1);
      rd(3'h0, 8'h01);
      $display("Test standard events done");
      wr(3'h1, 8'hB5);
      rd(3'h1, 8'hB5);
      wr(3'h3, 8'h5A);
      rd(3'h3, 8'h5A);
      wr(3'h6, 8'hF0);
      rd(3'h6, 8'hB0);
      wr(3'h0, 8'hFF);
      rd(3'h0, 8'h00);
      rd(3'h7, 8'h00);
      wr(3'h1, 8'h00);
      rd(3'h1, 8'h00);
      $display("Test enables done");
      for (int i = 0; i < 8; i++) begin
         op_conditions = 8'h01 << i;
         hit(5'h00, 3'h2, 8'h01 << i);
      end
      rd(3'h4, 8'h80);
      $display("Test operation events done");
      wr(3'h3, 8'h10);
      wr(3'h6, 8'h80);
      op_conditions = 8'h10;
      step(2);
      check("srq_line", {7'h00, srq_line}, 8'h01);
      check("status", status_byte, 8'hC0);
      wait_poll(8'hC0);
      check("status", status_byte, 8'hC0);
      op_conditions = 8'h00;
      step(1);
      op_conditions = 8'h10;
      step(4);
      check("srq_line", {7'h00, srq_line}, 8'h00);
      rd(3'h2, 8'h10);
      step(1);
      check("status", status_byte, 8'h00);
      poll_delay = 4'hA;
      op_conditions = 8'h00;
      step(1);
      op_conditions = 8'h10;
      step(2);
      check("srq_line", {7'h00, srq_line}, 8'h01);
      wait_poll(8'hC0);
      rd(3'h2, 8'h10);
      op_conditions = 8'h00;
      $display("Test service request done");
      wr(3'h1, 8'h20);
      wr(3'h6, 8'h30);
      message_available = 1'b1;
      step(2);
      check("status", status_byte, 8'h50);
      wait_poll(8'h50);
      hit(5'h01, 3'h5, 8'h70);
      rd(3'h5, 8'h70);
      message_available = 1'b0;
      hit(5'h10, 3'h5, 8'h00);
      rd(3'h0, 8'h00);
      clk_en = 1'b0;
      ev = 5'h01;
      step(2);
      ev = 5'h00;
      clk_en = 1'b1;
      rd(3'h0, 8'h00);
      $display("Test summary and clear done");
      wrap_up();
   end
endmodule : sesr_status_top_tb
